// ---- logic/sppi_pkg.sv ----
`default_nettype none
package sppi_pkg;

	// ----------------------------------------
	// bus widths
	// ----------------------------------------
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int KIND_W     = 2;
	localparam int FIFO_W     = KIND_W + ADDR_W + DATA_W;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------
	// synchronised pin vector layout
	// ----------------------------------------
	localparam int PB_ADDR   = 0;
	localparam int PB_DATA   = 8;
	localparam int PB_SEL_N  = 40;
	localparam int PB_RDEN_N = 41;
	localparam int PB_WRST_N = 42;
	localparam int PB_CHOICE = 43;
	localparam int PB_IRQ    = 44;
	localparam int PB_FWEN   = 45;
	localparam int PB_DONE   = 46;
	localparam int PB_GRNT_N = 47;
	localparam int PB_PIO    = 48;
	localparam int PB_BYPASS = 49;
	localparam int PIN_W     = 50;

	// idle pin levels: active-low strobes high, all else low
	localparam logic [PIN_W-1:0] PIN_RST = 50'h0_8700_0000_0000;

	// ----------------------------------------
	// access kinds carried with each word
	// ----------------------------------------
	localparam logic [KIND_W-1:0] KIND_REG      = 2'h0;
	localparam logic [KIND_W-1:0] KIND_DMA      = 2'h1;
	localparam logic [KIND_W-1:0] KIND_FW_PROTO = 2'h2;
	localparam logic [KIND_W-1:0] KIND_FW_LINK  = 2'h3;

	// ----------------------------------------
	// reset values of outputs
	// ----------------------------------------
	localparam logic RST_IRQ_HOST = 1'b0;
	localparam logic RST_BUSY     = 1'b0;
	localparam logic RST_XREQ_N   = 1'b1;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_WRITE   = 4'b0010,
		ST_READ    = 4'b0100,
		ST_RELEASE = 4'b1000
	} sppi_state_e;

endpackage // sppi_pkg
`default_nettype wire

// ---- logic/sppi_fifo.sv ----
`default_nettype none
module sppi_fifo #(
	parameter int WIDTH = 42,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [PW:0]      cnt_q, cnt_d;
	logic             push, pop;

	// ----------------------------------------
	// pointers and fill count
	// ----------------------------------------
	assign in_ready_o  = (cnt_q < (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem[rd_q];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		wr_d  = push ? wr_q + 1'b1 : wr_q;
		rd_d  = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end

endmodule // sppi_fifo
`default_nettype wire

// ---- logic/sppi_port.sv ----
// How it works
// - processor puts an 8-bit address on addr_in for each access.
// - device_select_n low starts an access; bus ignored while it is high.
// - read data driven only while select and read enable are both low.
// - write data taken when write strobe and select are both low.
// - controller_choice high routes download words to host_link_mcu, low to protocol_mcu.
// - irq_to_device high is a pending request from the processor.
// - irq_to_host high signals a device interrupt, low otherwise.
// - program-load handling only while firmware_load_enable is held high.
// - ready shows code can be taken; processor answers with load_finished.
// - busy high while host_link_mcu services an interrupt; no requests then.
// - hold_off_n low stalls the processor's current access.
// - xfer_request_n low asks for a DMA transfer, high otherwise.
// - cycles made with xfer_grant_n low are DMA transfers.
// - pio_continue high tells the device pio_continue PIO data follows.
// - pll_bypass_choice low selects crystal through PLL, high bypasses it.
// - all control inputs sampled by level, never by edge.
// - 32-bit data bus beside address, select, read and write enables.
`default_nettype none
module sppi_port
(
	input  wire logic                       clk_i,
	input  wire logic                       nrst_i,
	// processor pins
	input  wire logic [sppi_pkg::ADDR_W-1:0] addr_in_i,
	input  wire logic [sppi_pkg::DATA_W-1:0] data_i,
	output logic      [sppi_pkg::DATA_W-1:0] data_o,
	output logic                            data_oe_o,
	input  wire logic                       device_select_n_i,
	input  wire logic                       read_enable_n_i,
	input  wire logic                       write_strobe_n_i,
	input  wire logic                       controller_choice_i,
	input  wire logic                       irq_to_device_i,
	output logic                            irq_to_host_o,
	input  wire logic                       firmware_load_enable_i,
	output logic                            ready_o,
	input  wire logic                       load_finished_i,
	output logic                            busy_o,
	output logic                            hold_off_n_o,
	output logic                            xfer_request_n_o,
	input  wire logic                       xfer_grant_n_i,
	input  wire logic                       pio_continue_i,
	input  wire logic                       pll_bypass_choice_i,
	// core side: write words
	output logic                            wr_valid_o,
	input  wire logic                       wr_ready_i,
	output logic      [sppi_pkg::ADDR_W-1:0] wr_addr_o,
	output logic      [sppi_pkg::DATA_W-1:0] wr_data_o,
	output logic      [sppi_pkg::KIND_W-1:0] wr_kind_o,
	// core side: reads
	output logic                            rd_req_o,
	output logic      [sppi_pkg::ADDR_W-1:0] rd_addr_o,
	output logic      [sppi_pkg::KIND_W-1:0] rd_kind_o,
	input  wire logic                       rd_valid_i,
	input  wire logic [sppi_pkg::DATA_W-1:0] rd_data_i,
	// core side: status and control
	input  wire logic                       host_irq_i,
	input  wire logic                       svc_busy_i,
	input  wire logic                       dma_want_i,
	output logic                            irq_pending_o,
	output logic                            fw_loading_o,
	output logic                            pio_continue_o,
	output logic                            clk_bypass_o
);
	import sppi_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [KIND_W-1:0] kind_of(input logic grant, input logic load,
		input logic choice);
		if (grant) begin
			kind_of = KIND_DMA;
		end else if (load) begin
			kind_of = choice ? KIND_FW_LINK : KIND_FW_PROTO;
		end else begin
			kind_of = KIND_REG;
		end
	endfunction

	// ----------------------------------------
	// pin synchroniser and level filter
	// ----------------------------------------
	logic [PIN_W-1:0] raw;
	logic [PIN_W-1:0] s1_q, s2_q, s3_q, f_q, f_d;

	always_comb begin
		raw                       = '0;
		raw[PB_ADDR +: ADDR_W]    = addr_in_i;
		raw[PB_DATA +: DATA_W]    = data_i;
		raw[PB_SEL_N]             = device_select_n_i;
		raw[PB_RDEN_N]            = read_enable_n_i;
		raw[PB_WRST_N]            = write_strobe_n_i;
		raw[PB_CHOICE]            = controller_choice_i;
		raw[PB_IRQ]               = irq_to_device_i;
		raw[PB_FWEN]              = firmware_load_enable_i;
		raw[PB_DONE]              = load_finished_i;
		raw[PB_GRNT_N]            = xfer_grant_n_i;
		raw[PB_PIO]               = pio_continue_i;
		raw[PB_BYPASS]            = pll_bypass_choice_i;
		// level taken only once stages two and three agree
		f_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s1_q <= PIN_RST;
			s2_q <= PIN_RST;
			s3_q <= PIN_RST;
			f_q  <= PIN_RST;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= f_d;
		end
	end

	// ----------------------------------------
	// decoded levels
	// ----------------------------------------
	logic              sel, wr_acc, rd_acc, load, grant;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [KIND_W-1:0] kind;

	assign addr   = f_q[PB_ADDR +: ADDR_W];
	assign wdata  = f_q[PB_DATA +: DATA_W];
	assign sel    = !f_q[PB_SEL_N];
	assign wr_acc = sel && !f_q[PB_WRST_N];
	assign rd_acc = sel && !f_q[PB_RDEN_N] && f_q[PB_WRST_N];
	assign load   = f_q[PB_FWEN];
	assign grant  = !f_q[PB_GRNT_N];
	assign kind   = kind_of(grant, load, f_q[PB_CHOICE]);

	// ----------------------------------------
	// write buffer
	// ----------------------------------------
	logic              push, fifo_rdy;
	logic [FIFO_W-1:0] fifo_out;

	sppi_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (push),
		.in_ready_o  (fifo_rdy),
		.in_data_i   ({kind, addr, wdata}),
		.out_valid_o (wr_valid_o),
		.out_ready_i (wr_ready_i),
		.out_data_o  (fifo_out)
	);

	assign wr_kind_o = fifo_out[FIFO_W-1 -: KIND_W];
	assign wr_addr_o = fifo_out[DATA_W +: ADDR_W];
	assign wr_data_o = fifo_out[DATA_W-1:0];

	// ----------------------------------------
	// access state machine
	// ----------------------------------------
	sppi_state_e       st_q, st_d;
	logic              pend_q, pend_d;
	logic              dv_q, dv_d;
	logic              rreq_q, rreq_d;
	logic [ADDR_W-1:0] raddr_q, raddr_d;
	logic [KIND_W-1:0] rkind_q, rkind_d;
	logic [DATA_W-1:0] rdat_q, rdat_d;
	logic              take_ok;

	// a download word waits for the previous load_finished
	assign take_ok = fifo_rdy && !(load && pend_q);
	assign push    = (st_q == ST_IDLE) && wr_acc && take_ok;

	always_comb begin
		st_d    = st_q;
		pend_d  = pend_q;
		dv_d    = dv_q;
		rreq_d  = 1'b0;
		raddr_d = raddr_q;
		rkind_d = rkind_q;
		rdat_d  = rdat_q;
		if (load && f_q[PB_DONE]) begin
			pend_d = 1'b0;
		end
		if (!load) begin
			pend_d = 1'b0;
		end
		unique case (st_q)
			ST_IDLE: begin
				dv_d = 1'b0;
				if (push) begin
					st_d = ST_WRITE;
					if (load) begin
						pend_d = 1'b1;
					end
				end else if (rd_acc) begin
					rreq_d  = 1'b1;
					raddr_d = addr;
					rkind_d = kind;
					st_d    = ST_READ;
				end
			end
			ST_WRITE: begin
				st_d = ST_RELEASE;
			end
			ST_READ: begin
				if (!rd_acc) begin
					st_d = ST_IDLE;
				end else if (rd_valid_i) begin
					rdat_d = rd_data_i;
					dv_d   = 1'b1;
					st_d   = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				// one transfer per strobe level
				if (!wr_acc && !rd_acc) begin
					st_d = ST_IDLE;
					dv_d = 1'b0;
				end
			end
			default: begin
				st_d = ST_IDLE;
				dv_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_q    <= ST_IDLE;
			pend_q  <= 1'b0;
			dv_q    <= 1'b0;
			rreq_q  <= 1'b0;
			raddr_q <= '0;
			rkind_q <= KIND_REG;
			rdat_q  <= '0;
		end else begin
			st_q    <= st_d;
			pend_q  <= pend_d;
			dv_q    <= dv_d;
			rreq_q  <= rreq_d;
			raddr_q <= raddr_d;
			rkind_q <= rkind_d;
			rdat_q  <= rdat_d;
		end
	end

	// ----------------------------------------
	// processor-side handshakes
	// ----------------------------------------
	assign data_o    = rdat_q;
	assign data_oe_o = dv_q && rd_acc;
	assign rd_req_o  = rreq_q;
	assign rd_addr_o = raddr_q;
	assign rd_kind_o = rkind_q;

	always_comb begin
		hold_off_n_o = 1'b1;
		if ((st_q == ST_IDLE) && ((wr_acc && !take_ok) || rd_acc)) begin
			hold_off_n_o = 1'b0;
		end
		if ((st_q == ST_READ) && rd_acc) begin
			hold_off_n_o = 1'b0;
		end
	end

	assign ready_o = load && !pend_q && fifo_rdy;

	// ----------------------------------------
	// interrupts, DMA and status levels
	// ----------------------------------------
	logic irqh_q, irqh_d, busy_q, busy_d, xreq_q, xreq_d;

	always_comb begin
		irqh_d = host_irq_i;
		busy_d = svc_busy_i;
		xreq_d = !dma_want_i;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			irqh_q <= RST_IRQ_HOST;
			busy_q <= RST_BUSY;
			xreq_q <= RST_XREQ_N;
		end else begin
			irqh_q <= irqh_d;
			busy_q <= busy_d;
			xreq_q <= xreq_d;
		end
	end

	assign irq_to_host_o    = irqh_q;
	assign busy_o           = busy_q;
	assign xfer_request_n_o = xreq_q;

	// requests during busy are not passed on
	assign irq_pending_o  = f_q[PB_IRQ] && !busy_q;
	assign fw_loading_o   = load;
	assign pio_continue_o = f_q[PB_PIO];
	assign clk_bypass_o   = f_q[PB_BYPASS];

endmodule // sppi_port
`default_nettype wire

// ---- dv/sppi_port_props.sv ----
`default_nettype none
module sppi_port_props (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic host_irq_i,
	input wire logic svc_busy_i,
	input wire logic dma_want_i,
	input wire logic device_select_n_i,
	input wire logic firmware_load_enable_i,
	input wire logic pll_bypass_choice_i,
	input wire logic irq_to_host_o,
	input wire logic busy_o,
	input wire logic xfer_request_n_o,
	input wire logic hold_off_n_o,
	input wire logic ready_o,
	input wire logic data_oe_o,
	input wire logic irq_pending_o,
	input wire logic clk_bypass_o,
	input wire logic irq_to_device_i
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// ----------------------------------------
	// pin held at one level long enough to pass the filter
	// ----------------------------------------
	sequence s_hi7(s);
		s [*7];
	endsequence
	sequence s_busy2;
		busy_o [*2];
	endsequence
	a_reset_quiet: assert property (
		$rose(nrst_i) |-> !irq_to_host_o && !busy_o && xfer_request_n_o && hold_off_n_o && !ready_o)
		else $error("outputs not idle after reset");
	a_irq_follow: assert property (nrst_i |=> irq_to_host_o == $past(host_irq_i))
		else $error("host interrupt does not follow core");
	a_busy_follow: assert property (nrst_i |=> busy_o == $past(svc_busy_i))
		else $error("busy does not follow core");
	a_xreq_follow: assert property (nrst_i |=> xfer_request_n_o == !$past(dma_want_i))
		else $error("transfer request wrong level");
	a_sel_idle: assert property (s_hi7(device_select_n_i) |-> hold_off_n_o && !data_oe_o)
		else $error("activity while deselected");
	a_load_off: assert property (s_hi7(!firmware_load_enable_i) |-> !ready_o)
		else $error("ready outside load mode");
	a_irq_mask: assert property (s_busy2 |-> !irq_pending_o)
		else $error("request pending while busy");
	a_clk_bypass: assert property (s_hi7(pll_bypass_choice_i) |-> clk_bypass_o)
		else $error("bypass not selected");
	a_irq_pass: assert property (s_hi7(irq_to_device_i) ##0 !busy_o |-> irq_pending_o)
		else $error("request not pending while idle");
endmodule // sppi_port_props
`default_nettype wire

// ---- dv/sppi_proc.sv ----
`default_nettype none
module sppi_proc
	import sppi_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              hold_off_n_i,
	output logic      [ADDR_W-1:0] addr_o,
	output logic      [DATA_W-1:0] data_o,
	output logic                   sel_n_o,
	output logic                   rd_n_o,
	output logic                   wr_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{sel_n_o, rd_n_o, wr_n_o} = 3'h7;
		addr_o = '0;
		data_o = '0;
	end
	// ----------------------------------------
	// one access, held by level until the stall lifts
	// ----------------------------------------
	task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
			output logic ok);
		@(negedge clk_i);
		addr_o = a;
		data_o = d;
		sel_n_o = 1'b0;
		wr_n_o = !wr;
		rd_n_o = wr;
		repeat (6) @(negedge clk_i);
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(negedge clk_i);
			ok = (hold_off_n_i === 1'b1);
		end
	endtask
	task automatic rel();
		@(negedge clk_i);
		{sel_n_o, rd_n_o, wr_n_o} = 3'h7;
		addr_o = ~addr_o;
		data_o = ~data_o;
		repeat (6) @(negedge clk_i);
	endtask
endmodule // sppi_proc
`default_nettype wire

// ---- dv/sppi_port_bench.sv ----
`default_nettype none
module sppi_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import sppi_pkg::*;
	logic              clk_i, nrst_i, device_select_n_i, read_enable_n_i, write_strobe_n_i;
	logic              controller_choice_i, irq_to_device_i, irq_to_host_o, ready_o;
	logic              firmware_load_enable_i, load_finished_i, busy_o, hold_off_n_o;
	logic              xfer_request_n_o, xfer_grant_n_i, pio_continue_i, pll_bypass_choice_i;
	logic              data_oe_o, wr_valid_o, wr_ready_i, rd_req_o, rd_valid_i, host_irq_i;
	logic              svc_busy_i, dma_want_i, irq_pending_o, fw_loading_o, pio_continue_o;
	logic              clk_bypass_o;
	logic [ADDR_W-1:0] addr_in_i, wr_addr_o, rd_addr_o;
	logic [DATA_W-1:0] pdata, data_i, data_o, wr_data_o, rd_data_i;
	logic [KIND_W-1:0] wr_kind_o, rd_kind_o;
	logic [2:0]        rq;
	int                error_cnt, n_tests, cyc;
	assign data_i = data_oe_o ? data_o : pdata;
	assign rd_valid_i = rq[2];
	assign rd_data_i = {24'hA5A5A5, rd_addr_o};
	sppi_port dut (.clk_i, .nrst_i, .addr_in_i, .data_i, .data_o, .data_oe_o, .device_select_n_i,
		.read_enable_n_i, .write_strobe_n_i, .controller_choice_i, .irq_to_device_i,
		.irq_to_host_o, .firmware_load_enable_i, .ready_o, .load_finished_i, .busy_o,
		.hold_off_n_o, .xfer_request_n_o, .xfer_grant_n_i, .pio_continue_i, .pll_bypass_choice_i,
		.wr_valid_o, .wr_ready_i, .wr_addr_o, .wr_data_o, .wr_kind_o, .rd_req_o, .rd_addr_o,
		.rd_kind_o, .rd_valid_i, .rd_data_i, .host_irq_i, .svc_busy_i, .dma_want_i,
		.irq_pending_o, .fw_loading_o, .pio_continue_o, .clk_bypass_o);
	sppi_proc proc (.clk_i, .hold_off_n_i(hold_off_n_o), .addr_o(addr_in_i), .data_o(pdata),
		.sel_n_o(device_select_n_i), .rd_n_o(read_enable_n_i), .wr_n_o(write_strobe_n_i));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(negedge clk_i) rq <= {rq[1:0], rd_req_o};
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic ok;
		proc.acc(1'b1, a, d, ok);
		chk(ok, 1'b1);
		proc.rel();
	endtask
	task automatic pop(input logic [KIND_W-1:0] k, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d);
		for (int i = 0; i < 40 && wr_valid_o !== 1'b1; i++) @(negedge clk_i);
		chk({wr_valid_o, wr_kind_o, wr_addr_o, wr_data_o}, {1'b1, k, a, d});
		wr_ready_i = 1'b1;
		@(negedge clk_i);
		wr_ready_i = 1'b0;
	endtask
	task automatic t_side();
		for (int v = 0; v < 2; v++) begin
			{host_irq_i, svc_busy_i, dma_want_i, pio_continue_i, pll_bypass_choice_i} = {5{v[0]}};
			irq_to_device_i = 1'b1;
			repeat (8) @(negedge clk_i);
			chk(irq_to_host_o, v[0]);
			chk(busy_o, v[0]);
			chk(xfer_request_n_o, !v[0]);
			chk(irq_pending_o, !v[0]);
			chk(pio_continue_o, v[0]);
			chk(clk_bypass_o, v[0]);
		end
		{host_irq_i, svc_busy_i, dma_want_i, pio_continue_i, pll_bypass_choice_i} = '0;
		irq_to_device_i = 1'b0;
	endtask
	task automatic t_write();
		wr(8'h3C, 32'h1234_5678);
		pop(KIND_REG, 8'h3C, 32'h1234_5678);
		xfer_grant_n_i = 1'b0;
		wr(8'hC3, 32'h8765_4321);
		pop(KIND_DMA, 8'hC3, 32'h8765_4321);
		xfer_grant_n_i = 1'b1;
	endtask
	task automatic t_fw();
		firmware_load_enable_i = 1'b1;
		controller_choice_i = 1'b1;
		repeat (8) @(negedge clk_i);
		chk(ready_o, 1'b1);
		chk(fw_loading_o, 1'b1);
		wr(8'h01, 32'hCAFE_0001);
		chk(ready_o, 1'b0);
		load_finished_i = 1'b1;
		repeat (8) @(negedge clk_i);
		load_finished_i = 1'b0;
		repeat (8) @(negedge clk_i);
		chk(ready_o, 1'b1);
		pop(KIND_FW_LINK, 8'h01, 32'hCAFE_0001);
		controller_choice_i = 1'b0;
		repeat (8) @(negedge clk_i);
		wr(8'h02, 32'hCAFE_0002);
		pop(KIND_FW_PROTO, 8'h02, 32'hCAFE_0002);
		firmware_load_enable_i = 1'b0;
		repeat (8) @(negedge clk_i);
		chk(ready_o, 1'b0);
		chk(fw_loading_o, 1'b0);
	endtask
	task automatic t_rst();
		{host_irq_i, svc_busy_i, dma_want_i} = 3'h7;
		repeat (4) @(negedge clk_i);
		nrst_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk({irq_to_host_o, busy_o, xfer_request_n_o, hold_off_n_o, ready_o}, 5'h06);
		nrst_i = 1'b1;
		repeat (4) @(negedge clk_i);
		chk(irq_to_host_o, 1'b1);
		{host_irq_i, svc_busy_i, dma_want_i} = '0;
		repeat (8) @(negedge clk_i);
	endtask
	task automatic t_fifo();
		logic ok;
		for (int i = 0; i < FIFO_DEPTH; i++) wr(8'(i), 32'(i) ^ 32'h5500_0000);
		proc.acc(1'b1, 8'hFF, 32'hFFFF_FFFF, ok);
		chk(ok, 1'b0);
		chk(hold_off_n_o, 1'b0);
		proc.rel();
		for (int i = 0; i < FIFO_DEPTH; i++) pop(KIND_REG, 8'(i), 32'(i) ^ 32'h5500_0000);
		chk(wr_valid_o, 1'b0);
	endtask
	task automatic t_read();
		logic ok;
		proc.acc(1'b0, 8'h5A, 32'h0, ok);
		chk(ok, 1'b1);
		chk({data_oe_o, data_o}, {1'b1, 24'hA5A5A5, 8'h5A});
		chk(rd_kind_o, KIND_REG);
		chk(rd_addr_o, 8'h5A);
		proc.rel();
		chk(data_oe_o, 1'b0);
	endtask
	initial begin
		{nrst_i, controller_choice_i, irq_to_device_i, firmware_load_enable_i} = '0;
		{load_finished_i, pio_continue_i, pll_bypass_choice_i, wr_ready_i} = '0;
		{host_irq_i, svc_busy_i, dma_want_i, rq} = '0;
		xfer_grant_n_i = 1'b1;
		repeat (12) @(negedge clk_i);
		nrst_i = 1'b1;
		chk({irq_to_host_o, busy_o, xfer_request_n_o, hold_off_n_o, ready_o}, 5'h06);
		t_side();
		t_write();
		t_fw();
		t_fifo();
		t_read();
		t_rst();
		tally_and_finish();
	end
endmodule // sppi_port_bench
bind sppi_port sppi_port_props u_props (.clk_i, .nrst_i, .host_irq_i, .svc_busy_i, .dma_want_i,
	.device_select_n_i, .firmware_load_enable_i, .pll_bypass_choice_i, .irq_to_host_o, .busy_o,
	.xfer_request_n_o, .hold_off_n_o, .ready_o, .data_oe_o, .irq_pending_o, .clk_bypass_o,
	.irq_to_device_i);
`default_nettype wire
